// ==== hpioc_host_port.v ====
`timescale 1ns/10ps
`include "hpioc_consts.vh"


module hpioc_host_port (
  clk,
  rst_n,
  host_type_select_hi,
  host_type_select_lo,
  cs_n,
  rd_wr_n,
  addr,
  data_in,
  data_out,
  data_oe,
  ack_out,
  ack_oe,
  core_irq,
  irq_out,
  irq_oe,
  byte_width_select,
  endian_order_select,
  lane_invariance_select,
  polled_access_enable
);
  input  wire        clk;
  input  wire        rst_n;
  input  wire        host_type_select_hi;
  input  wire        host_type_select_lo;
  input  wire        cs_n;
  input  wire        rd_wr_n;
  input  wire [8:0]  addr;
  input  wire [15:0] data_in;
  output reg  [15:0] data_out;
  output reg         data_oe;
  output reg         ack_out;
  output reg         ack_oe;
  input  wire        core_irq;
  output reg         irq_out;
  output reg         irq_oe;
  output reg         byte_width_select;
  output reg         endian_order_select;
  output reg         lane_invariance_select;
  output reg         polled_access_enable;

  localparam ST_IDLE = 2'h0;
  localparam ST_CAPT = 2'h1;
  localparam ST_HOLD = 2'h2;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg        cs_s1;
  reg        cs_s2;
  reg        cs_s3;
  reg [25:0] bus_s1;
  reg [25:0] bus_s2;
  reg [1:0]  strap_s1;
  reg [1:0]  strap_s2;

  always @(posedge clk) begin
    if (!rst_n) begin
      cs_s1    <= 1'b1;
      cs_s2    <= 1'b1;
      cs_s3    <= 1'b1;
      bus_s1   <= 26'h0;
      bus_s2   <= 26'h0;
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
    end else begin
      cs_s1    <= cs_n;
      cs_s2    <= cs_s1;
      cs_s3    <= cs_s2;
      bus_s1   <= {rd_wr_n, addr, data_in};
      bus_s2   <= bus_s1;
      strap_s1 <= {host_type_select_hi, host_type_select_lo};
      strap_s2 <= strap_s1;
    end
  end

  // ----------------------------------------
  // Control and status state
  // ----------------------------------------
  reg [1:0]  state;
  reg [1:0]  init_cnt;
  reg [1:0]  host_type;
  reg [7:0]  io_ctrl;
  reg        stat_done;
  reg        stat_write;
  reg        ack_act;
  reg        cap_rd;
  reg [8:0]  cap_addr;
  reg [15:0] cap_data;
  reg [31:0] wbuf;
  reg [3:0]  wmask;
  reg [6:0]  wqidx;

  // ----------------------------------------
  // Host type defaults
  // ----------------------------------------
  function [7:0] host_default;
    input [1:0] ht;
    begin
      case (ht)
        `HPIOC_HOST_SYNC:    host_default = `HPIOC_DEF_SYNC;
        `HPIOC_HOST_ASYNC16: host_default = `HPIOC_DEF_ASYNC16;
        `HPIOC_HOST_MCU8:    host_default = `HPIOC_DEF_MCU8;
        default:             host_default = `HPIOC_DEF_RSVD;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Quadlet and lane decode
  // ----------------------------------------
  function is_ctrl_q;
    input [6:0] q;
    begin
      is_ctrl_q = (q == `HPIOC_IO_CONTROL_QIDX);
    end
  endfunction

  function is_stat_q;
    input [6:0] q;
    begin
      is_stat_q = (q == `HPIOC_POLL_STATUS_QIDX);
    end
  endfunction

  function [31:0] lane_bits;
    input [3:0] m;
    begin
      lane_bits = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    end
  endfunction

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  wire [6:0] qidx = cap_addr[8:2];
  reg  [31:0] quad_rd;

  always @* begin
    quad_rd = 32'h0;
    if (is_ctrl_q(qidx)) begin
      quad_rd[7:0] = io_ctrl;
      if (host_type == `HPIOC_HOST_MCU8) begin
        quad_rd[`HPIOC_BIT_ACK_DRIVE] = 1'b0;
      end
    end else if (is_stat_q(qidx)) begin
      quad_rd[`HPIOC_STAT_DONE]  = stat_done;
      quad_rd[`HPIOC_STAT_WRITE] = stat_write;
    end
  end

  wire [3:0]  lane_mask;
  wire [31:0] quad_wdata;
  wire [15:0] host_rdata;

  hpioc_stack u_stack (
    .word_mode  (~io_ctrl[`HPIOC_BIT_BYTE_WIDTH]),
    .big_endian (io_ctrl[`HPIOC_BIT_ENDIAN]),
    .lane_inv   (io_ctrl[`HPIOC_BIT_LANE_INV]),
    .byte_addr  (cap_addr[1:0]),
    .host_wdata (cap_data),
    .quad_rdata (quad_rd),
    .lane_mask  (lane_mask),
    .quad_wdata (quad_wdata),
    .host_rdata (host_rdata)
  );

  wire        cs_fall   = cs_s3 & ~cs_s2;
  wire        wr_clash  = (wmask != 4'h0) & ((wqidx != qidx) | ((wmask & lane_mask) != 4'h0));
  wire [3:0]  next_mask = wmask | lane_mask;
  wire [31:0] next_wbuf = (wbuf & ~lane_bits(lane_mask)) | quad_wdata;
  wire        is_status = is_stat_q(qidx);

  // ----------------------------------------
  // Transaction engine
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      init_cnt   <= 2'h0;
      host_type  <= `HPIOC_HOST_SYNC;
      io_ctrl    <= `HPIOC_DEF_SYNC;
      stat_done  <= 1'b0;
      stat_write <= 1'b0;
      ack_act    <= 1'b0;
      cap_rd     <= 1'b0;
      cap_addr   <= 9'h0;
      cap_data   <= 16'h0;
      wbuf       <= 32'h0;
      wmask      <= 4'h0;
      wqidx      <= 7'h0;
      data_out   <= 16'h0;
      data_oe    <= 1'b0;
    end else begin
      if (init_cnt != `HPIOC_STRAP_DONE_CNT) begin
        init_cnt <= init_cnt + 2'h1;
      end
      if (init_cnt == `HPIOC_STRAP_LOAD_CNT) begin
        host_type <= strap_s2;
        io_ctrl   <= host_default(strap_s2);
      end
      case (state)
        ST_IDLE: begin
          if (cs_fall && init_cnt == `HPIOC_STRAP_DONE_CNT) begin
            cap_rd   <= bus_s2[25];
            cap_addr <= bus_s2[24:16];
            cap_data <= bus_s2[15:0];
            state    <= ST_CAPT;
          end
        end
        ST_CAPT: begin
          if (cap_rd) begin
            data_out <= host_rdata;
            data_oe  <= 1'b1;
            wmask    <= 4'h0;
          end else if (wr_clash) begin
            wmask <= 4'h0;
          end else if (next_mask == 4'hF) begin
            wmask <= 4'h0;
            if (is_ctrl_q(qidx)) begin
              io_ctrl <= next_wbuf[7:0] & `HPIOC_CTRL_MASK;
            end
          end else begin
            wbuf  <= next_wbuf;
            wmask <= next_mask;
            wqidx <= qidx;
          end
          if (!(cap_rd && is_status)) begin
            stat_done  <= 1'b1;
            stat_write <= ~cap_rd;
          end
          ack_act <= ~io_ctrl[`HPIOC_BIT_POLLED];
          state   <= ST_HOLD;
        end
        ST_HOLD: begin
          if (cs_s2) begin
            ack_act <= 1'b0;
            data_oe <= 1'b0;
            state   <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (state == ST_IDLE && cs_fall && init_cnt == `HPIOC_STRAP_DONE_CNT
          && !(bus_s2[25] && is_stat_q(bus_s2[24:18]))) begin
        stat_done <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin drivers and control outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      ack_out                <= 1'b1;
      ack_oe                 <= 1'b0;
      irq_out                <= 1'b1;
      irq_oe                 <= 1'b0;
      byte_width_select      <= 1'b0;
      endian_order_select    <= 1'b0;
      lane_invariance_select <= 1'b0;
      polled_access_enable   <= 1'b0;
    end else begin
      ack_out <= io_ctrl[`HPIOC_BIT_ACK_POL] ? ack_act : ~ack_act;
      ack_oe  <= (host_type != `HPIOC_HOST_MCU8)
                 & (io_ctrl[`HPIOC_BIT_ACK_DRIVE] | ack_act);
      irq_out <= io_ctrl[`HPIOC_BIT_IRQ_POL] ? core_irq : ~core_irq;
      irq_oe  <= io_ctrl[`HPIOC_BIT_IRQ_DRIVE] | core_irq;
      byte_width_select      <= io_ctrl[`HPIOC_BIT_BYTE_WIDTH];
      endian_order_select    <= io_ctrl[`HPIOC_BIT_ENDIAN];
      lane_invariance_select <= io_ctrl[`HPIOC_BIT_LANE_INV] & ~io_ctrl[`HPIOC_BIT_ENDIAN];
      polled_access_enable   <= io_ctrl[`HPIOC_BIT_POLLED];
    end
  end
endmodule

// ==== hpioc_consts.vh ====
`ifndef HPIOC_CONSTS_VH
`define HPIOC_CONSTS_VH

// ----------------------------------------
// Register map, quadlet indices of 9-bit byte address
// ----------------------------------------
`define HPIOC_IO_CONTROL_OFS     9'h1EC
`define HPIOC_POLL_STATUS_OFS    9'h1F0
`define HPIOC_IO_CONTROL_QIDX    7'h7B
`define HPIOC_POLL_STATUS_QIDX   7'h7C

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define HPIOC_BIT_BYTE_WIDTH     0
`define HPIOC_BIT_ENDIAN         1
`define HPIOC_BIT_IRQ_POL        2
`define HPIOC_BIT_ACK_DRIVE      3
`define HPIOC_BIT_IRQ_DRIVE      4
`define HPIOC_BIT_POLLED         5
`define HPIOC_BIT_LANE_INV       6
`define HPIOC_BIT_ACK_POL        7
`define HPIOC_CTRL_MASK          8'hFF

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define HPIOC_STAT_DONE          0
`define HPIOC_STAT_WRITE         1

// ----------------------------------------
// Host type codes and control defaults
// ----------------------------------------
`define HPIOC_HOST_SYNC          2'h0
`define HPIOC_HOST_ASYNC16       2'h1
`define HPIOC_HOST_MCU8          2'h2
`define HPIOC_HOST_RSVD          2'h3
`define HPIOC_DEF_SYNC           8'h72
`define HPIOC_DEF_ASYNC16        8'h42
`define HPIOC_DEF_MCU8           8'h61
`define HPIOC_DEF_RSVD           8'h42

// ----------------------------------------
// Reset strap capture count
// ----------------------------------------
`define HPIOC_STRAP_LOAD_CNT     2'h2
`define HPIOC_STRAP_DONE_CNT     2'h3

`endif

// ==== hpioc_stack.v ====
`timescale 1ns/10ps
`include "hpioc_consts.vh"

module hpioc_stack (
  word_mode,
  big_endian,
  lane_inv,
  byte_addr,
  host_wdata,
  quad_rdata,
  lane_mask,
  quad_wdata,
  host_rdata
);
  input  wire        word_mode;
  input  wire        big_endian;
  input  wire        lane_inv;
  input  wire [1:0]  byte_addr;
  input  wire [15:0] host_wdata;
  input  wire [31:0] quad_rdata;
  output reg  [3:0]  lane_mask;
  output reg  [31:0] quad_wdata;
  output reg  [15:0] host_rdata;

  // ----------------------------------------
  // Quadlet byte lane of a host byte address
  // ----------------------------------------
  function [1:0] lane_of;
    input [1:0] a;
    input       big;
    begin
      lane_of = big ? (2'h3 - a) : a;
    end
  endfunction

  reg [1:0]  lane_lo;
  reg [1:0]  lane_hi;
  reg [15:0] wswap;
  reg        swap;

  // ----------------------------------------
  // Placement and extraction
  // ----------------------------------------
  always @* begin
    lane_lo    = lane_of(byte_addr, big_endian);
    lane_hi    = lane_of({byte_addr[1], 1'b1}, big_endian);
    swap       = ~big_endian & lane_inv;
    wswap      = swap ? {host_wdata[7:0], host_wdata[15:8]} : host_wdata;
    lane_mask  = 4'h0;
    quad_wdata = 32'h0;
    host_rdata = 16'h0;
    if (word_mode) begin
      lane_lo = lane_of({byte_addr[1], 1'b0}, big_endian);
      lane_mask[lane_lo] = 1'b1;
      lane_mask[lane_hi] = 1'b1;
      quad_wdata[lane_lo*8 +: 8] = wswap[15:8];
      quad_wdata[lane_hi*8 +: 8] = wswap[7:0];
      host_rdata[15:8] = quad_rdata[lane_lo*8 +: 8];
      host_rdata[7:0]  = quad_rdata[lane_hi*8 +: 8];
      if (swap) begin
        host_rdata = {quad_rdata[lane_hi*8 +: 8], quad_rdata[lane_lo*8 +: 8]};
      end
    end else begin
      lane_mask[lane_lo] = 1'b1;
      quad_wdata[lane_lo*8 +: 8] = host_wdata[7:0];
      host_rdata[7:0] = quad_rdata[lane_lo*8 +: 8];
    end
  end
endmodule

// ==== hpioc_host_port_asserts.sv ====
`timescale 1ns/10ps
module hpioc_checker (
  input wire clk,
  input wire rst_n,
  input wire host_type_select_hi,
  input wire host_type_select_lo,
  input wire cs_n,
  input wire rd_wr_n,
  input wire data_oe,
  input wire ack_oe,
  input wire core_irq,
  input wire irq_out,
  input wire irq_oe,
  input wire byte_width_select,
  input wire endian_order_select,
  input wire lane_invariance_select,
  input wire polled_access_enable
);
  // ----
  // Cycles since reset release, saturating
  // ----
  logic [3:0] up_cnt;
  always @(posedge clk) begin
    if (!rst_n) begin
      up_cnt <= 4'h0;
    end else if (up_cnt != 4'hF) begin
      up_cnt <= up_cnt + 4'h1;
    end
  end
  wire [2:0] sel_now = {byte_width_select, endian_order_select, polled_access_enable};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_irq_oe_follow: assert property (up_cnt > 4'h1 && $past(core_irq) |-> irq_oe)
    else $error("irq enable low while irq raised");
  a_irq_level_track: assert property (up_cnt > 4'h1 && $changed(core_irq) |=> $changed(irq_out))
    else $error("irq pin missed a change");
  a_data_needs_cs: assert property ($rose(data_oe) |-> !cs_n && !$past(cs_n, 3))
    else $error("data driven without select");
  a_data_release: assert property ($rose(cs_n) |-> ##[1:4] !data_oe)
    else $error("data bus held after select end");
  a_lane_big_endian: assert property (lane_invariance_select |-> !endian_order_select)
    else $error("lane swap active in big endian");
  a_mcu_no_ack: assert property (host_type_select_hi && !host_type_select_lo |-> !ack_oe)
    else $error("ack driven in byte host mode");
  a_ack_hold_cs: assert property (!polled_access_enable && $fell(ack_oe) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("ack released before select end");
  a_select_on_write: assert property (up_cnt == 4'hF && $changed(sel_now) |->
    !$past(cs_n, 2) && !$past(rd_wr_n, 2))
    else $error("select changed without a write");
endmodule

bind hpioc_host_port hpioc_checker u_chk (.clk(clk), .rst_n(rst_n), .host_type_select_hi(host_type_select_hi),
  .host_type_select_lo(host_type_select_lo), .cs_n(cs_n), .rd_wr_n(rd_wr_n), .data_oe(data_oe),
  .ack_oe(ack_oe), .core_irq(core_irq), .irq_out(irq_out), .irq_oe(irq_oe),
  .byte_width_select(byte_width_select), .endian_order_select(endian_order_select),
  .lane_invariance_select(lane_invariance_select), .polled_access_enable(polled_access_enable));

// ==== hpioc_host_model.sv ====
`timescale 1ns/10ps
module hpioc_host_model (
  input  wire         clk,
  input  wire  [15:0] data_out,
  input  wire         ack_out,
  input  wire         ack_oe,
  output logic        cs_n,
  output logic        rd_wr_n,
  output logic [8:0]  addr,
  output logic [15:0] data_in
);
  initial begin
    cs_n = 1'b1;
    rd_wr_n = 1'b1;
    addr = 9'h000;
    data_in = 16'h0000;
  end
  // ----
  // One bus cycle, handshake or polled
  // ----
  task automatic xfer(input logic wr, input logic [8:0] a, input logic [15:0] d, input logic hs,
                      input logic pol, output logic [15:0] rd, output logic ok);
    int n;
    ok = !hs;
    @(posedge clk);
    cs_n <= 1'b0;
    rd_wr_n <= !wr;
    addr <= a;
    data_in <= d;
    for (n = 0; n < 40 && hs && !ok; n++) begin
      @(posedge clk);
      ok = (ack_oe === 1'b1) && (ack_out === pol);
    end
    if (!hs) repeat (8) @(posedge clk);
    rd = data_out;
    cs_n <= 1'b1;
    addr <= ~a;
    data_in <= ~d;
    repeat (26) @(posedge clk);
  endtask
endmodule

// ==== host_port_io_control_tb_top.sv ====
`timescale 1ns/10ps
module host_port_io_control_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        host_type_select_hi = 1'b0;
  logic        host_type_select_lo = 1'b0;
  logic        core_irq = 1'b0;
  wire         cs_n, rd_wr_n, data_oe, ack_out, ack_oe, irq_out, irq_oe;
  wire         byte_width_select, endian_order_select, lane_invariance_select, polled_access_enable;
  wire  [8:0]  addr;
  wire  [15:0] data_in, data_out;
  wire  [3:0]  sel_seen = {byte_width_select, endian_order_select, polled_access_enable, lane_invariance_select};
  logic [15:0] rd;
  logic        ok;
  int          n_mismatch = 0;
  int          checks_done = 0;
  initial forever #2 clk = ~clk;
  hpioc_host_port uut (.clk(clk), .rst_n(rst_n), .host_type_select_hi(host_type_select_hi),
    .host_type_select_lo(host_type_select_lo), .cs_n(cs_n), .rd_wr_n(rd_wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ack_out(ack_out), .ack_oe(ack_oe),
    .core_irq(core_irq), .irq_out(irq_out), .irq_oe(irq_oe), .byte_width_select(byte_width_select),
    .endian_order_select(endian_order_select), .lane_invariance_select(lane_invariance_select),
    .polled_access_enable(polled_access_enable));
  hpioc_host_model hm (.clk(clk), .data_out(data_out), .ack_out(ack_out), .ack_oe(ack_oe),
    .cs_n(cs_n), .rd_wr_n(rd_wr_n), .addr(addr), .data_in(data_in));
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] ht);
    @(posedge clk);
    rst_n <= 1'b0;
    host_type_select_hi <= ht[1];
    host_type_select_lo <= ht[0];
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic io(input logic rnw, input logic [8:0] a, input logic [15:0] d, input logic hs, input logic pol);
    hm.xfer(!rnw, a, d, hs, pol, rd, ok);
    if (!ok) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic sel_chk(input logic [7:0] v);
    check(sel_seen, {v[0], v[1], v[5], v[6] & !v[1]});
  endtask
  task automatic irq_chk(input logic lvl, input logic [1:0] exp);
    @(posedge clk);
    core_irq <= lvl;
    repeat (3) @(posedge clk);
    check({irq_out, irq_oe}, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_defaults;
    logic [7:0] dv [4] = '{8'h72, 8'h42, 8'h61, 8'h42};
    for (int t = 0; t < 4; t++) begin
      do_reset(t[1:0]);
      sel_chk(dv[t]);
      check({irq_out, irq_oe}, {1'b1, dv[t][4]});
      io(1'b1, dv[t][0] ? 9'h1EC : 9'h1EE, 16'h0000, !dv[t][5], 1'b0);
      check(rd[7:0], dv[t]);
    end
  endtask
  task automatic s_word_ctrl;
    do_reset(2'h0);
    io(1'b0, 9'h1EC, 16'hFFFF, 1'b0, 1'b0);
    sel_chk(8'h72);
    io(1'b0, 9'h1EE, 16'hAB8F, 1'b0, 1'b0);
    sel_chk(8'h8F);
    io(1'b1, 9'h1EF, 16'h0000, 1'b1, 1'b1);
    check(rd[7:0], 8'h8F);
    io(1'b1, 9'h1ED, 16'h0000, 1'b1, 1'b1);
    check(rd[7:0], 8'h00);
    io(1'b1, 9'h1EE, 16'h0000, 1'b1, 1'b1);
    check(rd[7:0], 8'h00);
    io(1'b1, 9'h100, 16'h0000, 1'b1, 1'b1);
    check(rd[7:0], 8'h00);
    irq_chk(1'b1, 2'h3);
    irq_chk(1'b0, 2'h0);
    for (int b = 0; b < 3; b++) io(1'b0, 9'h1EC + b[8:0], 16'h0000, 1'b1, 1'b1);
    sel_chk(8'h8F);
    io(1'b0, 9'h1EF, 16'h00D4, 1'b1, 1'b1);
    sel_chk(8'hD4);
    irq_chk(1'b0, 2'h1);
    io(1'b0, 9'h1EC, 16'h0000, 1'b1, 1'b1);
    io(1'b0, 9'h1EC, 16'h0000, 1'b1, 1'b1);
    io(1'b0, 9'h1EE, 16'h0000, 1'b1, 1'b1);
    sel_chk(8'hD4);
    io(1'b1, 9'h1EC, 16'h0000, 1'b1, 1'b1);
    check(rd, 16'h00D4);
  endtask
  task automatic s_mcu;
    do_reset(2'h2);
    io(1'b0, 9'h1EC, 16'h0069, 1'b0, 1'b0);
    for (int b = 1; b < 4; b++) io(1'b0, 9'h1EC + b[8:0], 16'h0000, 1'b0, 1'b0);
    io(1'b1, 9'h1F0, 16'h0000, 1'b0, 1'b0);
    check(rd[7:0], 8'h03);
    io(1'b1, 9'h1EC, 16'h0000, 1'b0, 1'b0);
    check(rd[7:0], 8'h61);
    io(1'b1, 9'h1F0, 16'h0000, 1'b0, 1'b0);
    check(rd[7:0], 8'h01);
  endtask
  initial begin
    s_defaults();
    s_word_ctrl();
    s_mcu();
    give_verdict();
  end
endmodule
